// ===== logic/cad_pkg.sv
// shared types and constants of the core arithmetic datapath
package cad_pkg;

  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_SHIFT, OP_MUL, OP_DIV,
    OP_ACC_CLEAR, OP_SQ_DIFF, OP_SQ_DIFF_ACC, OP_MULT_ACC, OP_SQ_ACC,
    OP_ACC_PREFETCH, OP_MULT, OP_MULT_SQ, OP_MULT_NEGATE, OP_MULT_SUB,
    OP_ACC_ADD, OP_ACC_SUB, OP_ACC_NEGATE, OP_STORE, OP_STORE_ROUND,
    OP_ACC_SHIFT
  } cad_op_t;

  // integer multiply signedness: first letter operand a, second b
  typedef enum logic [1:0] {MUL_SS, MUL_UU, MUL_UxS, MUL_SxU} cad_mul_t;

  typedef enum logic [1:0] {DV_IDLE = 2'b01, DV_RUN = 2'b10} cad_dv_t;

  typedef struct packed {
    logic              vld;
    cad_op_t           op;
    logic              byteMode;
    cad_mul_t          mulMode;
    logic              lit5;
    logic              accSel;
    logic              wbEn;
    logic              xSrc;
    logic              arith;
    logic signed [5:0] shAmt;
    logic              divSigned;
    logic              div32;
    logic              toMem;
    logic [15:0]       opA;
    logic [15:0]       opB;
    logic [15:0]       opHi;
  } cad_req_t;

  // core_control_reg layout, bit 0 is multInt
  typedef struct packed {
    logic accSatMode;
    logic wrSat;
    logic acc_b_sat_enable;
    logic acc_a_sat_enable;
    logic roundConv;
    logic multUnsigned;
    logic multInt;
  } cad_ctl_t;

  typedef struct packed {
    logic digitCarry;
    logic overflow;
    logic negative;
    logic zero;
    logic carry;
  } cad_flags_t;

  localparam int          CTL_W      = 7;
  localparam int          FLG_W      = 5;
  localparam logic [7:0]  ADDR_CTL   = 8'h00;
  localparam logic [7:0]  ADDR_FLAGS = 8'h04;
  localparam logic [4:0]  DIV_LAST   = 5'h0f;
  localparam logic [15:0] HALF_LSW   = 16'h8000;
  localparam logic [15:0] SAT_POS    = 16'h7fff;
  localparam logic [15:0] SAT_NEG    = 16'h8000;
  localparam logic [39:0] MAX_N      = 40'h007fffffff;
  localparam logic [39:0] MIN_N      = 40'hff80000000;
  localparam logic [39:0] MAX_S      = 40'h7fffffffff;
  localparam logic [39:0] MIN_S      = 40'h8000000000;

  typedef struct packed {
    cad_ctl_t    ctl;
    cad_flags_t  flg;
    logic [39:0] accumulator_a;
    logic [39:0] accumulator_b;
    logic [31:0] res;
    logic        resVld;
    logic        toMem;
    logic [15:0] xb;
    logic        xbWe;
    cad_dv_t     dv;
    logic [4:0]  cnt;
    logic [15:0] rem;
    logic [15:0] quo;
    logic [15:0] dvs;
    logic        negQ;
    logic        negR;
    logic [15:0] wrkZero;
    logic [15:0] wrkOne;
    logic        wWe;
    logic        rdy;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cad_st_t;

endpackage

// ===== logic/cad_datapath.sv
// integer alu, multiplier, divider and dsp engine of the core
//
// Decided for this implementation: the APB slave port and the register offsets.

//////////////////////////////////////////////////////////////////////////////
module cad_datapath
  import cad_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire cad_req_t    req,
  output logic             reqReady,
  output logic [31:0]      resData,
  output logic             resValid,
  output logic             resToMem,
  output cad_flags_t       flags,
  output logic [15:0]      xbData,
  output logic             xbWrite,
  output logic [15:0]      wrkZero,
  output logic [15:0]      wrkOne,
  output logic             wrkWrite,
  output logic             divBusy,
  output logic [39:0]      accumulator_a,
  output logic [39:0]      accumulator_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  cad_st_t q;
  cad_st_t d;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [39:0] sat40(logic [40:0] s, logic en,
                                        logic md);
    logic ovS;
    logic ovN;
    ovS = s[40] ^ s[39];
    ovN = |s[40:31] & ~&s[40:31];
    if (en && (md ? ovS : ovN)) begin
      if (s[40]) return md ? MIN_S : MIN_N;
      return md ? MAX_S : MAX_N;
    end
    return s[39:0];
  endfunction

  function automatic logic [24:0] rnd(logic [39:0] a, logic conv,
                                      logic on);
    logic inc;
    inc = on & a[15];
    if (conv && a[15:0] == HALF_LSW) inc = on & a[16];
    return {a[39], a[39:16]} + {24'h0, inc};
  endfunction

  function automatic logic [15:0] wsat(logic [24:0] r, logic sgn,
                                       logic en);
    if (en && |r[24:15] && !(&r[24:15])) return sgn ? SAT_NEG : SAT_POS;
    return r[15:0];
  endfunction

  function automatic logic [39:0] bsh(logic [39:0] v,
                                      logic signed [5:0] n, logic ar);
    logic [5:0] m;
    m = 6'(-n);
    if (n < 0) return v << m;
    if (ar) return 40'($signed(v) >>> n);
    return v >> n;
  endfunction

  function automatic logic isDsp(cad_op_t o);
    return o >= OP_ACC_CLEAR;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // operand routing and datapath
  logic        go, sqOp, edOp, msa, msb, addSub, shPos;
  logic        ci, rMsb, nD, nV, ge;
  logic [39:0] accS, accO, p40, addL, addR, accNew, shIn, shOut;
  logic [15:0] dif, mx, my, bb, aluR, rn, qn;
  logic [33:0] prod;
  logic [40:0] sum41;
  logic [16:0] sw;
  logic [8:0]  sb;
  logic [4:0]  sn;
  logic [31:0] dvd;
  logic [31:0] mD;
  logic [16:0] t;

  assign go   = req.vld & q.rdy;
  assign accS = req.accSel ? q.accumulator_b : q.accumulator_a;
  assign accO = req.accSel ? q.accumulator_a : q.accumulator_b;
  assign dif  = req.opA - req.opB;
  assign edOp = req.op == OP_SQ_DIFF || req.op == OP_SQ_DIFF_ACC;
  assign sqOp = req.op == OP_SQ_ACC || req.op == OP_MULT_SQ;

  assign mx = req.op == OP_MUL && req.byteMode ? {8'h0, req.opA[7:0]} :
              edOp ? dif : req.opA;
  assign my = req.op == OP_MUL && req.byteMode ? {8'h0, req.opB[7:0]} :
              req.op == OP_MUL && req.lit5 ? {11'h0, req.opB[4:0]} :
              edOp ? dif : sqOp ? req.opA : req.opB;
  assign msa = isDsp(req.op) ? ~q.ctl.multUnsigned :
               ~req.byteMode &
               (req.mulMode == MUL_SS || req.mulMode == MUL_SxU);
  assign msb = isDsp(req.op) ? ~q.ctl.multUnsigned :
               ~req.byteMode & ~req.lit5 &
               (req.mulMode == MUL_SS || req.mulMode == MUL_UxS);

  assign prod = 34'($signed({msa & mx[15], mx}) *
                    $signed({msb & my[15], my}));
  // fractional product is aligned one bit left
  assign p40  = q.ctl.multInt ? {{6{prod[33]}}, prod} :
                {{5{prod[33]}}, prod, 1'b0};

  always_comb begin
    addL   = 40'h0;
    addR   = p40;
    addSub = 1'b0;
    unique case (req.op)
      OP_SQ_DIFF_ACC, OP_MULT_ACC, OP_SQ_ACC: addL = accS;
      OP_MULT_SUB: begin
        addL   = accS;
        addSub = 1'b1;
      end
      OP_MULT_NEGATE: addSub = 1'b1;
      OP_ACC_ADD: begin
        addL = accS;
        addR = accO;
      end
      OP_ACC_SUB: begin
        addL   = accS;
        addR   = accO;
        addSub = 1'b1;
      end
      OP_ACC_NEGATE: begin
        addR   = accS;
        addSub = 1'b1;
      end
      default: addR = p40;
    endcase
  end

  // 40-bit adder with a guard bit
  assign sum41  = addSub ? {addL[39], addL} - {addR[39], addR} :
                  {addL[39], addL} + {addR[39], addR};
  // clamp per the selected saturation mode
  assign accNew = sat40(sum41, req.accSel ? q.ctl.acc_b_sat_enable : q.ctl.acc_a_sat_enable,
                        q.ctl.accSatMode);

  // x bus enters at 16..31 for right, 0 for left
  assign shPos = ~req.shAmt[5] & |req.shAmt;
  assign shIn  = req.op == OP_ACC_SHIFT && !req.xSrc ? accS :
                 shPos ? {{8{req.arith & req.opA[15]}}, req.opA, 16'h0} :
                 {24'h0, req.opA};
  assign shOut = bsh(shIn, req.shAmt, req.arith);

  assign bb   = req.op == OP_SUB ? ~req.opB : req.opB;
  assign ci   = req.op == OP_SUB;
  assign sw   = {1'b0, req.opA} + {1'b0, bb} + {16'h0, ci};
  assign sb   = {1'b0, req.opA[7:0]} + {1'b0, bb[7:0]} + {8'h0, ci};
  assign sn   = {1'b0, req.opA[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
  always_comb begin
    unique case (req.op)
      OP_AND:   aluR = req.opA & req.opB;
      OP_IOR:   aluR = req.opA | req.opB;
      OP_XOR:   aluR = req.opA ^ req.opB;
      OP_SHIFT: aluR = shPos ? shOut[31:16] : shOut[15:0];
      default:  aluR = req.byteMode ? {8'h0, sb[7:0]} : sw[15:0];
    endcase
  end
  assign rMsb = req.byteMode ? aluR[7] : aluR[15];

  // dividend from the register pair when div32, else opA alone, magnitude form
  assign dvd = req.div32 ? {req.opHi, req.opA} :
               req.divSigned ? {{16{req.opA[15]}}, req.opA} :
               {16'h0, req.opA};
  assign nD  = req.divSigned & dvd[31];
  assign mD  = nD ? 32'h0 - dvd : dvd;
  assign nV  = req.divSigned & req.opB[15];
  // one restoring step per divisor bit
  assign t   = {q.rem, q.quo[15]};
  assign ge  = t >= {1'b0, q.dvs};
  assign rn  = ge ? 16'(t - {1'b0, q.dvs}) : t[15:0];
  assign qn  = {q.quo[14:0], ge};

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    d        = q;
    d.resVld = 1'b0;
    d.xbWe   = 1'b0;
    d.wWe    = 1'b0;
    // apb: answer registered in setup, seen in the access cycle
    d.pready  = psel & ~penable;
    d.pslverr = 1'b0;
    if (psel && !penable) begin
      d.prdata = 32'h0;
      if (paddr == ADDR_CTL) d.prdata = {25'h0, q.ctl};
      else if (paddr == ADDR_FLAGS) d.prdata = {26'h0, ~q.rdy, q.flg};
      else d.pslverr = 1'b1;
    end
    if (psel && penable && q.pready && pwrite && paddr == ADDR_CTL) begin
      d.ctl = pwdata[CTL_W-1:0];
    end
    // a request is taken only while idle
    if (go) begin
      d.toMem = req.toMem;
      unique case (req.op)
        OP_ADD, OP_SUB: begin
          d.res      = {16'h0, aluR};
          d.resVld   = 1'b1;
          d.flg.carry      = req.byteMode ? sb[8] : sw[16];
          d.flg.digitCarry = req.byteMode ? sn[4] : sb[8];
          d.flg.overflow   = req.byteMode ?
            (req.opA[7] == bb[7]) & (aluR[7] != req.opA[7]) :
            (req.opA[15] == bb[15]) & (aluR[15] != req.opA[15]);
          d.flg.negative   = rMsb;
          d.flg.zero = req.byteMode ? aluR[7:0] == 8'h0 : aluR == 16'h0;
        end
        OP_AND, OP_IOR, OP_XOR, OP_SHIFT: begin
          d.res      = {16'h0, aluR};
          d.resVld   = 1'b1;
          d.flg.negative = rMsb;
          d.flg.zero = req.byteMode ? aluR[7:0] == 8'h0 : aluR == 16'h0;
        end
        OP_MUL: begin
          d.res    = prod[31:0];
          d.resVld = 1'b1;
        end
        OP_DIV: begin
          d.dv   = DV_RUN;
          d.cnt  = 5'h0;
          d.rem  = mD[31:16];
          d.quo  = mD[15:0];
          d.dvs  = nV ? 16'h0 - req.opB : req.opB;
          d.negQ = nD ^ nV;
          d.negR = nD;
          d.rdy  = 1'b0;
        end
        OP_STORE, OP_STORE_ROUND: begin
          d.xb   = wsat(rnd(accS, q.ctl.roundConv,
                            req.op == OP_STORE_ROUND),
                        accS[39], q.ctl.wrSat);
          d.xbWe = 1'b1;
        end
        OP_ACC_PREFETCH: d.xbWe = 1'b0;
        default: begin
          if (req.accSel) begin
            d.accumulator_b = req.op == OP_ACC_CLEAR ? 40'h0 :
                     req.op == OP_ACC_SHIFT ? shOut : accNew;
          end else begin
            d.accumulator_a = req.op == OP_ACC_CLEAR ? 40'h0 :
                     req.op == OP_ACC_SHIFT ? shOut : accNew;
          end
        end
      endcase
      // writeback of the other accumulator, always rounded
      if (req.wbEn && (req.op == OP_ACC_CLEAR || req.op == OP_MULT_ACC ||
          req.op == OP_ACC_PREFETCH || req.op == OP_MULT_SUB)) begin
        d.xb   = wsat(rnd(accO, q.ctl.roundConv, 1'b1), accO[39],
                      q.ctl.wrSat);
        d.xbWe = 1'b1;
      end
    end
    // sixteen steps, busy until results land
    if (q.dv == DV_RUN) begin
      d.rem = rn;
      d.quo = qn;
      d.cnt = q.cnt + 5'h1;
      if (q.cnt == DIV_LAST) begin
        d.wrkZero = q.negQ ? 16'h0 - qn : qn;
        d.wrkOne  = q.negR ? 16'h0 - rn : rn;
        d.wWe     = 1'b1;
        d.dv      = DV_IDLE;
        d.rdy     = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q     <= '0;
      q.dv  <= DV_IDLE;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reqReady = q.rdy;
  assign resData  = q.res;
  assign resValid = q.resVld;
  assign resToMem = q.toMem;
  assign flags    = q.flg;
  assign xbData   = q.xb;
  assign xbWrite  = q.xbWe;
  assign wrkZero  = q.wrkZero;
  assign wrkOne   = q.wrkOne;
  assign wrkWrite = q.wWe;
  assign divBusy  = ~q.rdy;
  assign accumulator_a     = q.accumulator_a;
  assign accumulator_b     = q.accumulator_b;
  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic stA;
  assign stA = go && !req.accSel && !q.ctl.wrSat;

  div_done_a: assert property (go && req.op == OP_DIV |-> ##17 wrkWrite)
    else $error("divide did not finish in sixteen steps");
  div_busy_a: assert property (go && req.op == OP_DIV |=> divBusy[*8])
    else $error("busy dropped during divide");
  div_hold_a: assert property (divBusy |=> !resValid && !xbWrite)
    else $error("request accepted while busy");
  div_u16_a: assert property (go && req.op == OP_DIV && !req.divSigned &&
    !req.div32 && req.opB == 16'h0007 && req.opA == 16'h0064 |->
    ##17 wrkZero == 16'h000e && wrkOne == 16'h0002)
    else $error("wrong quotient or remainder");
  rnd_conv_a: assert property (stA && req.op == OP_STORE_ROUND &&
    !q.ctl.roundConv && q.accumulator_a[15] && q.accumulator_a[31:16] != SAT_POS |=>
    xbData == $past(q.accumulator_a[31:16]) + 16'h1)
    else $error("conventional round missed increment");
  rnd_tie_a: assert property (stA && req.op == OP_STORE_ROUND &&
    q.ctl.roundConv && q.accumulator_a[15:0] == HALF_LSW && !q.accumulator_a[16] |=>
    xbData == $past(q.accumulator_a[31:16]))
    else $error("convergent tie rounded up on even");
  trunc_a: assert property (stA && req.op == OP_STORE |=>
    xbWrite && xbData == $past(q.accumulator_a[31:16]))
    else $error("truncated store altered");
  wsat_pos_a: assert property (go && req.op == OP_STORE && !req.accSel &&
    q.ctl.wrSat && !q.accumulator_a[39] && |q.accumulator_a[38:31] |=>
    xbData == SAT_POS && accumulator_a == $past(q.accumulator_a))
    else $error("write saturation wrong");
  add_c_a: assert property (go && req.op == OP_ADD && !req.byteMode |=>
    flags.carry == $past(17'(req.opA + req.opB) >> 16))
    else $error("carry flag wrong");
  sh_zero_a: assert property (go && req.op == OP_SHIFT &&
    req.shAmt == 6'sd0 |=> resData[15:0] == $past(req.opA))
    else $error("zero shift changed operand");
  clr_a: assert property (go && req.op == OP_ACC_CLEAR && req.accSel |=>
    accumulator_b == 40'h0)
    else $error("clear left accumulator non-zero");
  apb_rdy_a: assert property (psel && !penable |=> pready)
    else $error("apb answer late");

  div_c:  cover property (wrkWrite);
  wb_c:   cover property (go && req.wbEn && req.op == OP_MULT_ACC);
  sat_c:  cover property (go && q.ctl.acc_a_sat_enable && sum41[40] != sum41[39]);
  apbw_c: cover property (psel && penable && pwrite && pready);

endmodule

// ===== tb/cad_core_model.sv
// far-side model: working registers and data memory word of the core
module cad_core_model
  import cad_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [15:0] wrkZero,
  input  wire logic [15:0] wrkOne,
  input  wire logic        wrkWrite,
  input  wire logic        divBusy,
  input  wire logic [15:0] xbData,
  input  wire logic        xbWrite,
  output logic      [15:0] regW0,
  output logic      [15:0] regW1,
  output logic      [15:0] memWord
);
  timeunit 1ns;
  timeprecision 100ps;

//////////////////////////////////////////////////////////////////////////////
  // quotient, remainder, held reads
  // results are taken only once the divider is idle, never mid-iteration
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regW0 <= 16'h0000;
      regW1 <= 16'h0000;
    end else if (wrkWrite && !divBusy) begin
      regW0 <= wrkZero;
      regW1 <= wrkOne;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memWord <= 16'h0000;
    end else if (xbWrite) begin
      memWord <= xbData;
    end
  end
endmodule

// ===== tb/tb_cad_datapath.sv
// self-checking bench of the core arithmetic datapath
module tb_cad_datapath
  import cad_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk    = 1'b0;
  logic        rst_n   = 1'b0;
  cad_req_t    req     = '0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        reqReady, resValid, resToMem, xbWrite, wrkWrite, divBusy;
  logic        pready, pslverr, apbErr;
  logic [31:0] resData, prdata, apbData;
  logic [15:0] xbData, wrkZero, wrkOne, regW0, regW1, memWord;
  logic [39:0] accumulator_a, accumulator_b;
  cad_flags_t  flags;
  int          failCount = 0;
  int          checked   = 0;
  int          seed      = 99581;
  cad_op_t     aluTab [5] = '{OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR};
  cad_mul_t    mulTab [6] = '{MUL_SS, MUL_UU, MUL_UxS, MUL_SxU, MUL_UU,
                              MUL_UU};
  logic [15:0] dvHi [4] = '{16'h0000, 16'h0000, 16'h0012, 16'hfffe};
  logic [15:0] dvLo [4] = '{16'h0064, 16'h8001, 16'h3456, 16'h1234};
  logic [15:0] dvDs [4] = '{16'h0007, 16'h0007, 16'h1234, 16'h0100};
  logic [15:0] rndA [5] = '{16'h00c0, 16'h0100, 16'h0101, 16'h7fff,
                            16'hff00};
  logic [15:0] rndB [5] = '{16'h0200, 16'h0080, 16'h0080, 16'h7fff,
                            16'h0080};
  logic [6:0]  ctlTab [3] = '{7'h21, 7'h01, 7'h09};
  logic [15:0] satExp [3] = '{16'h7fff, 16'h8000, 16'h7fff};

  always #2.5 mclk = ~mclk;

  cad_datapath cad_datapath_i (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .req      (req),
    .reqReady (reqReady),
    .resData  (resData),
    .resValid (resValid),
    .resToMem (resToMem),
    .flags    (flags),
    .xbData   (xbData),
    .xbWrite  (xbWrite),
    .wrkZero  (wrkZero),
    .wrkOne   (wrkOne),
    .wrkWrite (wrkWrite),
    .divBusy  (divBusy),
    .accumulator_a     (accumulator_a),
    .accumulator_b     (accumulator_b),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  cad_core_model cad_core_model_i (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .wrkZero  (wrkZero),
    .wrkOne   (wrkOne),
    .wrkWrite (wrkWrite),
    .divBusy  (divBusy),
    .xbData   (xbData),
    .xbWrite  (xbWrite),
    .regW0    (regW0),
    .regW1    (regW1),
    .memWord  (memWord)
  );

//////////////////////////////////////////////////////////////////////////////
  task automatic testDone();
    if (failCount == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    checked++;
    if (g !== e) begin
      failCount++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    apbData = prdata;
    apbErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input cad_req_t r);
    @(posedge mclk);
    req <= r;
    @(posedge mclk);
    req.vld <= 1'b0;
    #1;
  endtask

  function automatic cad_req_t mk(cad_op_t op, logic [15:0] a,
                                  logic [15:0] b);
    mk      = '0;
    mk.vld  = 1'b1;
    mk.op   = op;
    mk.opA  = a;
    mk.opB  = b;
  endfunction

  // rounding and write saturation of a stored accumulator
  function automatic logic [15:0] stv(logic [39:0] ac, logic rd,
                                      logic cv, logic ws);
    longint v;
    v = longint'($signed(ac));
    if (rd && ac[15] && (ac[15:0] != 16'h8000 || !cv || ac[16])) v += 65536;
    if (ws && !ac[39] && v > 64'sh7fffffff) return 16'h7fff;
    if (ws && ac[39] && v < -64'sh80000000) return 16'h8000;
    return v[31:16];
  endfunction

//////////////////////////////////////////////////////////////////////////////
  initial begin
    cad_req_t    r;
    cad_flags_t  fl;
    logic [39:0] ac;
    logic [15:0] e16;
    longint      pa, pb, q, rm;
    int          a, b, s, res, m, dm, hb, sh;
    logic        sub, sa, sb, sr;
    fl = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("reqReady", 1, reqReady);
    apb(1'b0, ADDR_CTL, 32'h0);
    chk("ctlReset", 0, apbData);
    apb(1'b1, ADDR_CTL, 32'h7f);
    apb(1'b0, ADDR_CTL, 32'h0);
    chk("ctl", 40'h7f, apbData);
    apb(1'b1, ADDR_FLAGS, 32'h1f);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("flagsReg", 0, apbData);
    apb(1'b0, 8'h08, 32'h0);
    chk("pslverr", 1, apbErr);
    chk("unmapped", 0, apbData);
    apb(1'b1, ADDR_CTL, 32'h0);
    // alu arithmetic and logic, byte and word wide
    for (int i = 0; i < 40; i++) begin
      r = mk(aluTab[i % 5], 16'($random(seed)), 16'($random(seed)));
      r.byteMode = i[3];
      r.toMem = i[2];
      m = r.byteMode ? 'hff : 'hffff;
      dm = r.byteMode ? 'hf : 'hff;
      hb = (m + 1) >> 1;
      a = r.opA & m;
      b = r.opB & m;
      case (r.op)
        OP_ADD:  s = a + b;
        OP_SUB:  s = a - b;
        OP_AND:  s = a & b;
        OP_IOR:  s = a | b;
        default: s = a ^ b;
      endcase
      res = s & m;
      sa = (a & hb) != 0;
      sb = (b & hb) != 0;
      sr = (res & hb) != 0;
      if (r.op inside {OP_ADD, OP_SUB}) begin
        sub = r.op == OP_SUB;
        fl.carry = sub ? a >= b : s > m;
        fl.digitCarry = sub ? (a & dm) >= (b & dm)
                            : ((a & dm) + (b & dm)) > dm;
        fl.overflow = ((sa ^ sb) == sub) && (sr != sa);
      end
      fl.zero = res == 0;
      fl.negative = sr;
      run(r);
      chk("resValid", 1, resValid);
      chk("alu", res, resData & m);
      chk("aluFlags", fl, flags);
      chk("toMem", i[2], resToMem);
    end
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("flagsReg", fl, apbData[4:0]);
    // integer multiply in every signedness, literal and byte mode
    for (int i = 0; i < 24; i++) begin
      r = mk(OP_MUL, 16'($random(seed)), 16'($random(seed)));
      r.mulMode = mulTab[i % 6];
      r.lit5 = (i % 6) inside {3, 4};
      r.byteMode = (i % 6) == 5;
      pa = longint'(r.opA);
      pb = longint'(r.opB);
      if (r.mulMode inside {MUL_SS, MUL_SxU}) pa = longint'($signed(r.opA));
      if (r.mulMode inside {MUL_SS, MUL_UxS}) pb = longint'($signed(r.opB));
      if (r.lit5) pb = longint'(r.opB[4:0]);
      if (r.byteMode) pa = longint'(r.opA[7:0]);
      if (r.byteMode) pb = longint'(r.opB[7:0]);
      run(r);
      chk("product", {8'h00, 32'(pa * pb)}, resData);
      chk("mulFlags", fl, flags);
    end
    // barrel shift over signed amounts -16 to 16
    for (sh = -16; sh <= 16; sh++) begin
      r = mk(OP_SHIFT, 16'($random(seed)), 16'h0000);
      r.shAmt = 6'(sh);
      r.arith = sh[0];
      if (sh > 0) e16 = r.arith ? 16'($signed(r.opA) >>> sh) : r.opA >> sh;
      else e16 = r.opA << -sh;
      fl.zero = e16 == 16'h0000;
      fl.negative = e16[15];
      run(r);
      chk("shift", e16, resData[15:0]);
      chk("shFlags", fl, flags);
    end
    // divide: both sizes, signed and unsigned, exact latency, requests refused while busy
    for (int i = 0; i < 4; i++) begin
      r = mk(OP_DIV, dvLo[i], dvDs[i]);
      r.opHi = dvHi[i];
      r.divSigned = i[0];
      r.div32 = i[1];
      pa = i[1] ? longint'({dvHi[i], dvLo[i]}) : longint'(dvLo[i]);
      if (i == 1) pa = longint'($signed(dvLo[i]));
      if (i == 3) pa = longint'($signed({dvHi[i], dvLo[i]}));
      pb = i[0] ? longint'($signed(dvDs[i])) : longint'(dvDs[i]);
      q = pa / pb;
      rm = pa % pb;
      @(posedge mclk);
      req <= r;
      @(posedge mclk);
      req <= mk(OP_ADD, 16'h0001, 16'h0001);
      for (int c = 1; c <= 16; c++) begin
        #1;
        chk("divBusy", 1, divBusy);
        chk("reqReady", 0, reqReady);
        chk("refused", 0, resValid);
        @(posedge mclk);
      end
      req <= '0;
      #1;
      chk("wrkWrite", 1, wrkWrite);
      chk("quotient", q[15:0], wrkZero);
      chk("remainder", rm[15:0], wrkOne);
      @(posedge mclk);
      #1;
      chk("regW0", q[15:0], regW0);
      chk("regW1", rm[15:0], regW1);
    end
    // store truncated and rounded in both rounding modes
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, ADDR_CTL, {29'h0, i[0], 2'b01});
      r = mk(OP_MULT, rndA[i / 2], rndB[i / 2]);
      run(r);
      pa = longint'($signed(r.opA)) * longint'($signed(r.opB));
      ac = pa[39:0];
      chk("accumulator_a", ac, accumulator_a);
      r = mk(OP_STORE, 16'h0000, 16'h0000);
      run(r);
      chk("xbWrite", 1, xbWrite);
      chk("store", stv(ac, 1'b0, i[0], 1'b0), xbData);
      r.op = OP_STORE_ROUND;
      run(r);
      chk("storeRnd", stv(ac, 1'b1, i[0], 1'b0), xbData);
    end
    // accumulator add, write saturation, adder saturation
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_CTL, {25'h0, ctlTab[i]});
      r = mk(OP_MULT, 16'h8000, 16'h8000);
      run(r);
      r.accSel = 1'b1;
      run(r);
      chk("accumulator_b", 40'h0040000000, accumulator_b);
      ac = i == 2 ? MAX_N : 40'h0080000000;
      run(mk(OP_ACC_ADD, 16'h0000, 16'h0000));
      chk("accAdd", ac, accumulator_a);
      run(mk(OP_STORE, 16'h0000, 16'h0000));
      chk("satStore", satExp[i], xbData);
      chk("accKept", ac, accumulator_a);
    end
    r = mk(OP_MULT_ACC, 16'h0000, 16'h0000);
    r.wbEn = 1'b1;
    run(r);
    chk("wbRnd", stv(40'h0040000000, 1'b1, 1'b0, 1'b0), xbData);
    @(posedge mclk);
    #1;
    chk("memWord", 16'h4000, memWord);
    run(mk(OP_SQ_DIFF, 16'h0005, 16'h0002));
    chk("sqDiff", 40'h9, accumulator_a);
    run(mk(OP_MULT_NEGATE, 16'h0003, 16'h0004));
    chk("mulNeg", 40'hfffffffff4, accumulator_a);
    run(mk(OP_ACC_SUB, 16'h0000, 16'h0000));
    chk("accSub", 40'hffbffffff4, accumulator_a);
    r = mk(OP_ACC_CLEAR, 16'h0000, 16'h0000);
    r.accSel = 1'b1;
    r.wbEn = 1'b1;
    run(r);
    chk("accClr", 40'h0, accumulator_b);
    chk("clrWb", 16'hc000, xbData);
    apb(1'b1, ADDR_CTL, 32'h0);
    run(mk(OP_MULT, 16'h4000, 16'h4000));
    chk("frac", 40'h0020000000, accumulator_a);
    testDone();
  end

  initial begin
    #400000;
    failCount++;
    testDone();
  end
endmodule
